// ### logic/chan_cfg_consts.svh
// register map, field positions, reset values and timing counts
// How it works
// - software sets pending flag with a command; hardware clears it after executing
// - opcode picks stop tx, restart tx, hunt, or block-check reset (bisync only)
// - gci bit makes opcode a gci command; else channel select 00/01/10, 11 reserved
// - software sets soft reset with pending; hardware clears it in reset sequence
// - force_tx_low drives layer-one tx data low, gci mode only
// - sync style zero gives one-bit pulse before data; one gives enveloping pulse
// - diag field selects normal, echo, internal loopback, loopback control
// - strobe select bits swap which data strobe marks b1 or b2
// - route fields send b2, b1, d to channel one/two/three; detached ones dropped
// - channel two and three detach bits remove them from the mux interface
// - physical mode selects non-mux, pcm, idl or gci
// - bit mask low byte covers b1, high byte b2, bit 0 first
// - each channel owns its own config, mode, sync, event, mask, status registers
// - wired-or select makes the channel tx driver open-drain
// - ext clock select feeds the baud generator from timer pin instead of clock
// - tx and rx clock source pick baud generator or external clock pin
// - baud generator reloads an 11-bit down counter, prescaled by 1 or 4
// - tx parity odd/zero/even/one; rx parity odd or even
// - parity enable adds and checks parity in both directions
// - rx and tx enable bits switch each direction on
`ifndef CHAN_CFG_CONSTS_SVH
`define CHAN_CFG_CONSTS_SVH

// register indices; byte address is four times the index
`define CMD_IDX 12'h860
`define BMASK_IDX 12'h8B2
`define SIFMODE_IDX 12'h8B4
`define CHAN0_BASE 12'h880
`define CHAN1_BASE 12'h890
`define CHAN2_BASE 12'h8A0
`define CLKCFG_OFS 4'h2
`define CHMODE_OFS 4'h4
`define DSYNC_OFS 4'h6
`define EVT_OFS 4'h8
`define EVMASK_OFS 4'hA
`define LSTAT_OFS 4'hC

// command fields
`define CMDF_RST 7
`define CMDF_GCI 6
`define CMDF_OPC 5:4
`define CMDF_CHSEL 2:1
`define CMDF_PEND 0
`define CMD_WMASK 8'hF7

// serial interface mode fields
`define SIF_FTL 15
`define SIF_SYNC 14
`define SIF_DIAG 13:12
`define SIF_B2STB 11
`define SIF_B1STB 10
`define SIF_B2R 9:8
`define SIF_B1R 7:6
`define SIF_DR 5:4
`define SIF_DET3 3
`define SIF_DET2 2
`define SIF_PM 1:0

// channel clock config fields
`define CC_WOR 15
`define CC_XCLK 14
`define CC_RXSRC 13
`define CC_TXSRC 12
`define CC_CDIV 11:1
`define CC_PRE 0

// channel mode fields
`define CM_TXPAR 15:14
`define CM_RXPAR 13
`define CM_PAREN 12
`define CM_RXEN 3
`define CM_TXEN 2
`define CM_MODE 1:0

// reset values
`define DSYNC_RST 16'h7000
`define REG16_RST 16'h0000

// command execution time and clock rate
`define CMD_LATENCY_NS 20
`define CLK_MHZ 200

`endif

// ### logic/chan_cfg_pkg.sv
// types shared by the channel configuration block
package chan_cfg_pkg;
   typedef enum logic [1:0] {
      CMD_IDLE = 2'b00,
      CMD_BUSY = 2'b01,
      CMD_EXEC = 2'b10
   } cmd_state_e;
   typedef enum logic [1:0] {
      OP_STOP_TX = 2'b00,
      OP_RESTART_TX = 2'b01,
      OP_HUNT = 2'b10,
      OP_BCHK_RESET = 2'b11
   } opcode_e;
   typedef enum logic [1:0] {
      PM_NONMUX = 2'b00,
      PM_PCM = 2'b01,
      PM_IDL = 2'b10,
      PM_GCI = 2'b11
   } phys_mode_e;
   typedef enum logic [1:0] {
      CH_HDLC = 2'b00,
      CH_ASYNC = 2'b01,
      CH_SYNC = 2'b10,
      CH_BISYNC = 2'b11
   } chan_mode_e;
endpackage

// ### logic/serial_channel_config_regs.sv
// apb register bank, command engine and per-channel clock/line logic
`include "chan_cfg_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module serial_channel_config_regs #(
   parameter int NCH = 3
) (
   input wire logic REF_CLK,
   input wire logic RESETN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [13:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic TIMER_IN,
   input wire logic [NCH-1:0] EXT_CLK_IN,
   input wire logic [3*NCH-1:0] LINE_IN,
   input wire logic [8*NCH-1:0] EVENT_IN,
   input wire logic SLOT_B1,
   input wire logic SLOT_B2,
   input wire logic SLOT_D,
   input wire logic [2:0] BIT_IDX,
   input wire logic L1_DATA_IN,
   input wire logic [NCH-1:0] TX_DATA_IN,
   input wire logic [8*NCH-1:0] TX_CHAR,
   input wire logic [8*NCH-1:0] RX_CHAR,
   input wire logic [NCH-1:0] RX_PAR_IN,
   input wire logic [NCH-1:0] RX_CHAR_VALID,
   output logic L1_TXD,
   output logic DATA_STROBE_ONE,
   output logic DATA_STROBE_TWO,
   output logic [1:0] SLOT_CHAN,
   output logic SLOT_BIT_USED,
   output logic SYNC_WIDE,
   output logic [1:0] SI_DIAG,
   output logic [1:0] PHYS_MODE,
   output logic [NCH-1:0] CHAN_ATTACHED,
   output logic [NCH-1:0] TXD_O,
   output logic [NCH-1:0] TXD_OE,
   output logic [NCH-1:0] TX_CLK,
   output logic [NCH-1:0] RX_CLK,
   output logic [NCH-1:0] TX_ENABLE,
   output logic [NCH-1:0] RX_ENABLE,
   output logic [NCH-1:0] TX_PARITY,
   output logic [NCH-1:0] RX_PAR_ERR,
   output logic [NCH-1:0] TX_STOPPED,
   output logic [NCH-1:0] HUNT_PULSE,
   output logic [NCH-1:0] BCHK_RESET,
   output logic GCI_CMD_VALID,
   output logic [1:0] GCI_OPCODE
);
   localparam int CMD_CYC_RAW = (`CMD_LATENCY_NS * `CLK_MHZ + 999) / 1000;
   localparam int CMD_CYC = (CMD_CYC_RAW < 1) ? 1 : CMD_CYC_RAW;
   localparam int NPIN = 1 + NCH + 3 * NCH;

   // map an index to a channel number, 3 when outside the channel windows
   function automatic logic [1:0] chan_of(input logic [11:0] idx);
      logic [11:0] b;
      b = idx & 12'hFF0;
      if (b == `CHAN0_BASE) chan_of = 2'h0;
      else if (b == `CHAN1_BASE) chan_of = 2'h1;
      else if (b == `CHAN2_BASE) chan_of = 2'h2;
      else chan_of = 2'h3;
   endfunction

   // route field to channel number, detached channels give "none"
   function automatic logic [1:0] route_eff(input logic [1:0] r, input logic d2,
                                              input logic d3);
      route_eff = r;
      if ((r == 2'h2 && d2) || (r == 2'h3 && d3)) route_eff = 2'h0;
   endfunction

   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic [31:0] rdata_d;
   logic hit_d;
   logic wr_fire;
   logic [11:0] idx;
   logic [1:0] wch;
   logic [7:0] cmd_q;
   logic [15:0] sif_q;
   logic [15:0] bmask_q;
   chan_cfg_pkg::cmd_state_e st_q;
   logic [7:0] cnt_q;
   logic soft_rst_q;
   logic [16*NCH-1:0] cc_v;
   logic [16*NCH-1:0] cm_v;
   logic [16*NCH-1:0] ds_v;
   logic [8*NCH-1:0] ev_v;
   logic [8*NCH-1:0] em_v;
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] pin_f;
   logic timer_prev_q;
   logic timer_rise;

   assign idx = PADDR[13:2];
   assign wch = chan_of(idx);
   assign wr_fire = PSEL & PENABLE & PWRITE & pready_q;
   assign pin_raw = {LINE_IN, EXT_CLK_IN, TIMER_IN};
   assign timer_rise = pin_f[0] & ~timer_prev_q;

   // pin synchronisers: three stages, a change counts when stages two and three agree
   genvar p;
   generate
      for (p = 0; p < NPIN; p++) begin : g_pin
         logic [2:0] s_q;
         logic f_q;
         always_ff @(posedge REF_CLK or negedge RESETN) begin
            if (!RESETN) begin
               s_q <= 3'h0;
               f_q <= 1'b0;
            end else begin
               s_q <= {s_q[1:0], pin_raw[p]};
               if (s_q[1] == s_q[2]) f_q <= s_q[2];
            end
         end
         assign pin_f[p] = f_q;
      end
   endgenerate

   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) timer_prev_q <= 1'b0;
      else timer_prev_q <= pin_f[0];
   end

   // read mux; the 8-bit registers sit in the low byte
   always_comb begin
      rdata_d = 32'h0;
      hit_d = 1'b1;
      if (PADDR[1:0] != 2'h0) begin
         hit_d = 1'b0;
      end else if (idx == `CMD_IDX) begin
         rdata_d[7:0] = cmd_q;
      end else if (idx == `BMASK_IDX) begin
         rdata_d[15:0] = bmask_q;
      end else if (idx == `SIFMODE_IDX) begin
         rdata_d[15:0] = sif_q;
      end else if (wch != 2'h3 && int'(wch) < NCH) begin
         unique case (idx[3:0])
            `CLKCFG_OFS: rdata_d[15:0] = cc_v[16*wch +: 16];
            `CHMODE_OFS: rdata_d[15:0] = cm_v[16*wch +: 16];
            `DSYNC_OFS: rdata_d[15:0] = ds_v[16*wch +: 16];
            `EVT_OFS: rdata_d[7:0] = ev_v[8*wch +: 8];
            `EVMASK_OFS: rdata_d[7:0] = em_v[8*wch +: 8];
            `LSTAT_OFS: rdata_d[2:0] = pin_f[1 + NCH + 3*wch +: 3];
            default: hit_d = 1'b0;
         endcase
      end else begin
         hit_d = 1'b0;
      end
   end

   // apb answer: one wait state, ready and data both from flops
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
      end else begin
         pready_q <= PSEL & PENABLE & ~pready_q;
         if (PSEL & PENABLE & ~pready_q) begin
            pslverr_q <= ~hit_d;
            prdata_q <= PWRITE ? 32'h0 : rdata_d;
         end else begin
            pslverr_q <= 1'b0;
         end
      end
   end

   // global mode and mask registers
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         sif_q <= `REG16_RST;
         bmask_q <= `REG16_RST;
      end else if (wr_fire && PADDR[1:0] == 2'h0) begin
         if (idx == `SIFMODE_IDX) sif_q <= PWDATA[15:0];
         if (idx == `BMASK_IDX) bmask_q <= PWDATA[15:0];
      end
   end

   // command engine; writes are refused while a command is pending
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         cmd_q <= 8'h00;
         st_q <= chan_cfg_pkg::CMD_IDLE;
         cnt_q <= 8'h00;
         soft_rst_q <= 1'b0;
         TX_STOPPED <= '0;
         HUNT_PULSE <= '0;
         BCHK_RESET <= '0;
         GCI_CMD_VALID <= 1'b0;
         GCI_OPCODE <= 2'h0;
      end else begin
         soft_rst_q <= 1'b0;
         HUNT_PULSE <= '0;
         BCHK_RESET <= '0;
         GCI_CMD_VALID <= 1'b0;
         unique case (st_q)
            chan_cfg_pkg::CMD_IDLE: begin
               if (wr_fire && PADDR[1:0] == 2'h0 && idx == `CMD_IDX && !cmd_q[`CMDF_PEND])
                  cmd_q <= PWDATA[7:0] & `CMD_WMASK;
               if (cmd_q[`CMDF_PEND]) begin
                  st_q <= chan_cfg_pkg::CMD_BUSY;
                  cnt_q <= 8'(CMD_CYC - 1);
               end
            end
            chan_cfg_pkg::CMD_BUSY: begin
               if (cnt_q == 8'h00) st_q <= chan_cfg_pkg::CMD_EXEC;
               else cnt_q <= cnt_q - 8'h01;
            end
            chan_cfg_pkg::CMD_EXEC: begin
               st_q <= chan_cfg_pkg::CMD_IDLE;
               cmd_q[`CMDF_PEND] <= 1'b0;
               if (cmd_q[`CMDF_RST]) begin
                  // soft reset outranks the opcode
                  cmd_q[`CMDF_RST] <= 1'b0;
                  soft_rst_q <= 1'b1;
                  TX_STOPPED <= '0;
               end else if (cmd_q[`CMDF_GCI]) begin
                  GCI_CMD_VALID <= 1'b1;
                  GCI_OPCODE <= cmd_q[`CMDF_OPC];
               end else if (cmd_q[`CMDF_CHSEL] != 2'h3 && int'(cmd_q[`CMDF_CHSEL]) < NCH) begin
                  unique case (chan_cfg_pkg::opcode_e'(cmd_q[`CMDF_OPC]))
                     chan_cfg_pkg::OP_STOP_TX: TX_STOPPED[cmd_q[`CMDF_CHSEL]] <= 1'b1;
                     chan_cfg_pkg::OP_RESTART_TX: TX_STOPPED[cmd_q[`CMDF_CHSEL]] <= 1'b0;
                     chan_cfg_pkg::OP_HUNT: HUNT_PULSE[cmd_q[`CMDF_CHSEL]] <= 1'b1;
                     chan_cfg_pkg::OP_BCHK_RESET: begin
                        // only meaningful for a channel in bisync mode
                        if (cm_v[16*cmd_q[`CMDF_CHSEL] +: 2] == chan_cfg_pkg::CH_BISYNC)
                           BCHK_RESET[cmd_q[`CMDF_CHSEL]] <= 1'b1;
                     end
                  endcase
               end
            end
            default: st_q <= chan_cfg_pkg::CMD_IDLE;
         endcase
      end
   end

   // multiplexed serial interface outputs
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      logic [1:0] r;
      logic muxed;
      if (!RESETN) begin
         L1_TXD <= 1'b1;
         DATA_STROBE_ONE <= 1'b0;
         DATA_STROBE_TWO <= 1'b0;
         SLOT_CHAN <= 2'h0;
         SLOT_BIT_USED <= 1'b0;
         SYNC_WIDE <= 1'b0;
         SI_DIAG <= 2'h0;
         PHYS_MODE <= 2'h0;
         CHAN_ATTACHED <= '0;
      end else begin
         muxed = sif_q[`SIF_PM] == chan_cfg_pkg::PM_IDL || sif_q[`SIF_PM] == chan_cfg_pkg::PM_GCI;
         // force low only counts in gci; elsewhere the bit is ignored
         L1_TXD <= (sif_q[`SIF_PM] == chan_cfg_pkg::PM_GCI && sif_q[`SIF_FTL]) ? 1'b0
                   : L1_DATA_IN;
         SYNC_WIDE <= sif_q[`SIF_SYNC];
         SI_DIAG <= sif_q[`SIF_DIAG];
         PHYS_MODE <= sif_q[`SIF_PM];
         CHAN_ATTACHED <= '0;
         CHAN_ATTACHED[0] <= 1'b1;
         if (NCH > 1) CHAN_ATTACHED[1] <= ~sif_q[`SIF_DET2];
         if (NCH > 2) CHAN_ATTACHED[2] <= ~sif_q[`SIF_DET3];
         // strobes: b1 defaults to strobe one, b2 to strobe two
         DATA_STROBE_ONE <= muxed & ((SLOT_B1 & ~sif_q[`SIF_B1STB])
                                     | (SLOT_B2 & sif_q[`SIF_B2STB]));
         DATA_STROBE_TWO <= muxed & ((SLOT_B1 & sif_q[`SIF_B1STB])
                                     | (SLOT_B2 & ~sif_q[`SIF_B2STB]));
         if (SLOT_B1) r = sif_q[`SIF_B1R];
         else if (SLOT_B2) r = sif_q[`SIF_B2R];
         else if (SLOT_D) r = sif_q[`SIF_DR];
         else r = 2'h0;
         SLOT_CHAN <= (sif_q[`SIF_PM] == chan_cfg_pkg::PM_NONMUX) ? 2'h0
                      : route_eff(r, sif_q[`SIF_DET2], sif_q[`SIF_DET3]);
         // b-channel bit mask, low byte b1, high byte b2
         if (!muxed) SLOT_BIT_USED <= 1'b1;
         else if (SLOT_B1) SLOT_BIT_USED <= bmask_q[{1'b0, BIT_IDX}];
         else if (SLOT_B2) SLOT_BIT_USED <= bmask_q[{1'b1, BIT_IDX}];
         else SLOT_BIT_USED <= 1'b1;
      end
   end

   // one independent register set and clock path per channel
   genvar c;
   generate
      for (c = 0; c < NCH; c++) begin : g_ch
         logic [15:0] cc_q;
         logic [15:0] cm_q;
         logic [15:0] ds_q;
         logic [7:0] ev_q;
         logic [7:0] em_q;
         logic [1:0] pre_q;
         logic [10:0] div_q;
         logic brg_q;
         logic hit;
         logic src_tick;
         logic pre_tick;
         logic [7:0] w1c;
         logic ext_clk;

         assign hit = wr_fire && PADDR[1:0] == 2'h0 && wch == 2'(c);
         assign ext_clk = pin_f[1 + c];
         assign w1c = (hit && idx[3:0] == `EVT_OFS) ? PWDATA[7:0] : 8'h00;
         // timer pin rising edges or every system clock drive the prescaler
         assign src_tick = cc_q[`CC_XCLK] ? timer_rise : 1'b1;
         assign pre_tick = src_tick & (~cc_q[`CC_PRE] | (pre_q == 2'h3));

         // config registers; soft reset clears the whole mode register, mode back to hdlc
         always_ff @(posedge REF_CLK or negedge RESETN) begin
            if (!RESETN) begin
               cc_q <= `REG16_RST;
               cm_q <= `REG16_RST;
               ds_q <= `DSYNC_RST;
               em_q <= 8'h00;
            end else if (soft_rst_q) begin
               cm_q <= `REG16_RST;
            end else if (hit) begin
               if (idx[3:0] == `CLKCFG_OFS) cc_q <= PWDATA[15:0];
               if (idx[3:0] == `CHMODE_OFS) cm_q <= PWDATA[15:0];
               if (idx[3:0] == `DSYNC_OFS) ds_q <= PWDATA[15:0];
               if (idx[3:0] == `EVMASK_OFS) em_q <= PWDATA[7:0];
            end
         end

         // events are sticky; a new event beats a same-cycle clear
         always_ff @(posedge REF_CLK or negedge RESETN) begin
            if (!RESETN) ev_q <= 8'h00;
            else if (soft_rst_q) ev_q <= EVENT_IN[8*c +: 8];
            else ev_q <= (ev_q & ~w1c) | EVENT_IN[8*c +: 8];
         end

         // baud generator: down counter reloads from the divide field at zero
         always_ff @(posedge REF_CLK or negedge RESETN) begin
            if (!RESETN) begin
               pre_q <= 2'h0;
               div_q <= 11'h000;
               brg_q <= 1'b0;
            end else begin
               if (src_tick) pre_q <= cc_q[`CC_PRE] ? pre_q + 2'h1 : 2'h0;
               if (pre_tick) begin
                  if (div_q == 11'h000) begin
                     div_q <= cc_q[`CC_CDIV];
                     brg_q <= ~brg_q;
                  end else begin
                     div_q <= div_q - 11'h001;
                  end
               end
            end
         end

         // line side outputs
         always_ff @(posedge REF_CLK or negedge RESETN) begin
            if (!RESETN) begin
               TX_CLK[c] <= 1'b0;
               RX_CLK[c] <= 1'b0;
               TXD_O[c] <= 1'b1;
               TXD_OE[c] <= 1'b0;
               TX_ENABLE[c] <= 1'b0;
               RX_ENABLE[c] <= 1'b0;
               TX_PARITY[c] <= 1'b0;
               RX_PAR_ERR[c] <= 1'b0;
            end else begin
               TX_CLK[c] <= cc_q[`CC_TXSRC] ? ext_clk : brg_q;
               RX_CLK[c] <= cc_q[`CC_RXSRC] ? ext_clk : brg_q;
               TX_ENABLE[c] <= cm_q[`CM_TXEN];
               RX_ENABLE[c] <= cm_q[`CM_RXEN];
               // open drain only ever pulls low, so a one releases the pin
               if (cc_q[`CC_WOR]) begin
                  TXD_O[c] <= 1'b0;
                  TXD_OE[c] <= cm_q[`CM_TXEN] & ~TX_DATA_IN[c];
               end else begin
                  TXD_O[c] <= TX_DATA_IN[c];
                  TXD_OE[c] <= cm_q[`CM_TXEN];
               end
               if (!cm_q[`CM_PAREN]) TX_PARITY[c] <= 1'b0;
               else begin
                  unique case (cm_q[`CM_TXPAR])
                     2'h0: TX_PARITY[c] <= ~(^TX_CHAR[8*c +: 8]);
                     2'h1: TX_PARITY[c] <= 1'b0;
                     2'h2: TX_PARITY[c] <= ^TX_CHAR[8*c +: 8];
                     2'h3: TX_PARITY[c] <= 1'b1;
                  endcase
               end
               // even: total ones even; odd: total ones odd
               RX_PAR_ERR[c] <= cm_q[`CM_PAREN] & cm_q[`CM_RXEN] & RX_CHAR_VALID[c]
                  & ((^{RX_CHAR[8*c +: 8], RX_PAR_IN[c]}) == cm_q[`CM_RXPAR]);
            end
         end

         assign cc_v[16*c +: 16] = cc_q;
         assign cm_v[16*c +: 16] = cm_q;
         assign ds_v[16*c +: 16] = ds_q;
         assign ev_v[8*c +: 8] = ev_q;
         assign em_v[8*c +: 8] = em_q;
      end
   endgenerate

   assign PRDATA = prdata_q;
   assign PREADY = pready_q;
   assign PSLVERR = pslverr_q;
endmodule // serial_channel_config_regs
`default_nettype wire

// ### test/serial_channel_config_regs_assertions.sv
// port-level checker for the channel configuration register block
`timescale 1ns/1ps
`default_nettype none
module serial_channel_config_regs_assertions #(
   parameter int NCH = 3
) (
   input wire logic REF_CLK,
   input wire logic RESETN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic L1_DATA_IN,
   input wire logic SLOT_B1,
   input wire logic SLOT_B2,
   input wire logic L1_TXD,
   input wire logic DATA_STROBE_ONE,
   input wire logic DATA_STROBE_TWO,
   input wire logic [1:0] SLOT_CHAN,
   input wire logic [1:0] PHYS_MODE,
   input wire logic [NCH-1:0] CHAN_ATTACHED,
   input wire logic [NCH-1:0] TXD_OE,
   input wire logic [NCH-1:0] TX_ENABLE,
   input wire logic [NCH-1:0] HUNT_PULSE,
   input wire logic GCI_CMD_VALID
);
   // one clock domain, so clocking and reset are given once
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RESETN);
   // exactly one wait state, ready for one cycle only
   a_ready_wait: assert property (PSEL && PENABLE && !$past(PENABLE) |-> !PREADY ##1 PREADY)
      else $error("ready not on second access cycle");
   a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready held too long");
   a_err_ready: assert property (PSLVERR |-> PREADY) else $error("error without ready");
   // line output lags its data input by one stage
   a_force_low: assert property (!L1_TXD && $past(L1_DATA_IN) |-> PHYS_MODE == 2'h3)
      else $error("layer one data low outside gci");
   a_route_two: assert property (SLOT_CHAN == 2'h2 |-> CHAN_ATTACHED[1])
      else $error("slot routed to detached channel two");
   a_route_three: assert property (SLOT_CHAN == 2'h3 |-> CHAN_ATTACHED[2])
      else $error("slot routed to detached channel three");
   a_strobe_excl: assert property (!(DATA_STROBE_ONE && DATA_STROBE_TWO))
      else $error("both data strobes high");
   a_strobe_slot: assert property (DATA_STROBE_ONE || DATA_STROBE_TWO |->
      $past(SLOT_B1 || SLOT_B2) && PHYS_MODE[1]) else $error("strobe outside b slot");
   a_oe_enable: assert property (TXD_OE[0] |-> TX_ENABLE[0])
      else $error("tx driver on while disabled");
   a_hunt_pulse: assert property (HUNT_PULSE[0] |=> !HUNT_PULSE[0])
      else $error("hunt pulse longer than a cycle");
   a_gci_pulse: assert property (GCI_CMD_VALID |=> !GCI_CMD_VALID)
      else $error("gci valid longer than a cycle");
endmodule // serial_channel_config_regs_assertions
`default_nettype wire

// ### test/serial_channel_config_regs_tb_top.sv
// self-checking bench for the channel configuration register block
`timescale 1ns/1ps
`default_nettype none
module serial_channel_config_regs_tb_top;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, l1_txd, s1, s2, used, sw, l1_in;
   logic sb1, sb2, sd;
   logic [2:0] bidx, ext_clk, txd_in, txd_o, txd_oe, tx_clk, rx_clk, tx_en, rx_en, tx_par;
   logic [2:0] stopped, attached;
   logic [1:0] slot_chan, pm, diag, gci_op;
   logic [13:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic [8:0] line_in;
   logic [23:0] ev_in, tx_char;
   int num_errors, compares, cycles;

   serial_channel_config_regs #(.NCH(3)) dut (
      .REF_CLK(clk), .RESETN(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .TIMER_IN(1'h0), .EXT_CLK_IN(ext_clk), .LINE_IN(line_in), .EVENT_IN(ev_in),
      .SLOT_B1(sb1), .SLOT_B2(sb2), .SLOT_D(sd), .BIT_IDX(bidx), .L1_DATA_IN(l1_in),
      .TX_DATA_IN(txd_in), .TX_CHAR(tx_char), .RX_CHAR(24'h000000), .RX_PAR_IN(3'h0),
      .RX_CHAR_VALID(3'h0), .L1_TXD(l1_txd), .DATA_STROBE_ONE(s1), .DATA_STROBE_TWO(s2),
      .SLOT_CHAN(slot_chan), .SLOT_BIT_USED(used), .SYNC_WIDE(sw), .SI_DIAG(diag),
      .PHYS_MODE(pm), .CHAN_ATTACHED(attached), .TXD_O(txd_o), .TXD_OE(txd_oe),
      .TX_CLK(tx_clk), .RX_CLK(rx_clk), .TX_ENABLE(tx_en), .RX_ENABLE(rx_en),
      .TX_PARITY(tx_par), .RX_PAR_ERR(), .TX_STOPPED(stopped), .HUNT_PULSE(),
      .BCHK_RESET(), .GCI_CMD_VALID(), .GCI_OPCODE(gci_op));

   // free-running 200 MHz clock
   initial begin
      clk = 1'h0;
      forever #2.5 clk = ~clk;
   end

   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic w(input int n);
      repeat (n) @(posedge clk);
   endtask

   // one apb transfer; an idle cycle follows so strobes never reassert in one step
   task automatic xfer(input logic wr, input logic [13:0] a, input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      @(posedge clk);
      while (pready !== 1'h1) @(posedge clk);
      rdata = prdata;
      chk("pslverr", 32'(pslverr), 32'(a < 14'h2180 || a[1:0] != 2'h0));
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clk);
   endtask

   task automatic rdc(input string nm, input logic [13:0] a, input logic [31:0] e);
      xfer(1'h0, a, 32'h0);
      chk(nm, rdata, e);
   endtask

   // command, with slack for the engine to finish
   task automatic cmd(input logic [7:0] v);
      xfer(1'h1, 14'h2180, 32'(v));
      w(12);
      rdc("cmd_done", 14'h2180, 32'(v & 8'h76));
      chk("cmd_flags", rdata & 32'h81, 32'h0);
   endtask

   task automatic slot(input logic [3:0] s, input logic [4:0] e);
      {sb1, sb2, sd} <= s[3:1];
      bidx <= {2'h0, s[0]};
      w(4);
      chk("slot", 32'({slot_chan, s1, s2, used}), 32'(e));
   endtask

   task close_out();
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // hang guard, well above the test length
   always @(posedge clk) begin
      cycles++;
      if (cycles > 20000) begin
         num_errors++;
         close_out();
      end
   end

   // main sequence
   initial begin
      {rst_n, psel, penable, pwrite, sb1, sb2, sd} = 7'h00;
      {l1_in, bidx, ext_clk, txd_in, paddr, pwdata, line_in, ev_in, tx_char} = 0;
      repeat (16) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      for (int c = 0; c < 3; c++)
         for (int o = 2; o < 14; o += 2)
            rdc("reset", 14'(32'h2200 + c * 64 + o * 4), (o == 6) ? 32'h7000 : 32'h0);
      rdc("unmapped", 14'h0000, 32'h0);
      rdc("misaligned", 14'h2182, 32'h0);
      $display("register reset test done");
      for (int i = 0; i < 4; i++) begin
         l1_in <= i != 2;
         xfer(1'h1, 14'h22D0, 32'(i * 16'h5001));
         w(4);
         chk("mode", 32'({sw, diag, pm}), 32'({i[0], i[1:0], i[1:0]}));
         chk("l1_txd", 32'(l1_txd), 32'(i < 2));
      end
      xfer(1'h1, 14'h22C8, 32'h0001);
      xfer(1'h1, 14'h22D0, 32'h039A);
      w(4);
      chk("attached", 32'(attached), 32'h3);
      slot(4'h8, 5'h15);
      slot(4'h9, 5'h14);
      slot(4'h4, 5'h02);
      slot(4'h2, 5'h09);
      xfer(1'h1, 14'h22D0, 32'h0792);
      slot(4'h4, 5'h1A);
      slot(4'h8, 5'h13);
      chk("attached", 32'(attached), 32'h7);
      xfer(1'h1, 14'h22D0, 32'h0F92);
      slot(4'h4, 5'h1C);
      slot(4'h0, 5'h01);
      $display("serial interface test done");
      xfer(1'h1, 14'h2210, 32'h000C);
      xfer(1'h1, 14'h2208, 32'h8000);
      w(6);
      chk("txd", 32'({txd_o[0], txd_oe[0]}), 32'h1);
      txd_in <= 3'h7;
      w(6);
      chk("txd", 32'({txd_o[0], txd_oe[0]}), 32'h0);
      xfer(1'h1, 14'h2208, 32'h3000);
      w(6);
      chk("txd", 32'({txd_o[0], txd_oe[0]}), 32'h3);
      chk("enables", 32'({rx_en[0], tx_en[0]}), 32'h3);
      ext_clk <= 3'h1;
      w(8);
      chk("clk_src", 32'({tx_clk[0], rx_clk[0]}), 32'h3);
      ext_clk <= 3'h0;
      w(8);
      chk("clk_src", 32'({tx_clk[0], rx_clk[0]}), 32'h0);
      tx_char <= 24'h000001;
      for (int i = 0; i < 5; i++) begin
         xfer(1'h1, 14'h2210, 32'((i % 4) * 32'h4000 + ((i < 4) ? 32'h100C : 32'h000C)));
         w(4);
         chk("tx_parity", 32'(tx_par[0]), 32'((i / 2) % 2));
      end
      xfer(1'h1, 14'h2248, 32'hFFFF);
      rdc("ch2_clk", 14'h2248, 32'hFFFF);
      rdc("ch1_clk", 14'h2208, 32'h3000);
      rdc("ch3_clk", 14'h2288, 32'h0000);
      ev_in <= 24'h000100;
      @(posedge clk);
      ev_in <= 24'h000000;
      rdc("events", 14'h2260, 32'h1);
      xfer(1'h1, 14'h2260, 32'h1);
      rdc("events", 14'h2260, 32'h0);
      line_in <= 9'h038;
      w(6);
      xfer(1'h1, 14'h2270, 32'h0);
      rdc("line_status", 14'h2270, 32'h7);
      $display("channel test done");
      xfer(1'h1, 14'h2180, 32'h9);
      xfer(1'h1, 14'h2180, 32'h3);
      w(12);
      chk("stopped", 32'(stopped), 32'h1);
      xfer(1'h1, 14'h2180, 32'hB);
      rdc("cmd_bit3", 14'h2180, 32'h3);
      w(12);
      chk("stopped", 32'(stopped), 32'h3);
      cmd(8'h13);
      chk("stopped", 32'(stopped), 32'h1);
      cmd(8'h21);
      cmd(8'h31);
      cmd(8'h55);
      chk("gci_op", 32'(gci_op), 32'h1);
      cmd(8'h07);
      chk("stopped", 32'(stopped), 32'h1);
      cmd(8'h81);
      chk("stopped", 32'(stopped), 32'h0);
      rdc("mode_cleared", 14'h2210, 32'h0);
      $display("command test done");
      close_out();
   end
endmodule // serial_channel_config_regs_tb_top

bind serial_channel_config_regs serial_channel_config_regs_assertions #(.NCH(NCH)) chk_i (
   .REF_CLK(REF_CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
   .PSLVERR(PSLVERR), .L1_DATA_IN(L1_DATA_IN), .SLOT_B1(SLOT_B1), .SLOT_B2(SLOT_B2),
   .L1_TXD(L1_TXD), .DATA_STROBE_ONE(DATA_STROBE_ONE), .DATA_STROBE_TWO(DATA_STROBE_TWO),
   .SLOT_CHAN(SLOT_CHAN), .PHYS_MODE(PHYS_MODE), .CHAN_ATTACHED(CHAN_ATTACHED),
   .TXD_OE(TXD_OE), .TX_ENABLE(TX_ENABLE), .HUNT_PULSE(HUNT_PULSE),
   .GCI_CMD_VALID(GCI_CMD_VALID));
`default_nettype wire
